/* File: hw/fsv_map.vh */
`ifndef FSV_MAP_VH
`define FSV_MAP_VH

// ----------------------------------------
// command codes seen on the serial link
// ----------------------------------------
`define FSV_CMD_RD_SEG     8'hC8
`define FSV_CMD_WR_SEG     8'hC5
`define FSV_CMD_RD_EVCR    8'h65
`define FSV_CMD_WR_EVCR    8'h61

// ----------------------------------------
// segment-extension register layout
// ----------------------------------------
`define FSV_SEG_LSB        0
`define FSV_SEG_MSB        1
`define FSV_SEG_LOWER      2'h0
`define FSV_SEG_UPPER      2'h3

// ----------------------------------------
// enhanced volatile configuration layout
// ----------------------------------------
`define FSV_EVCR_QUAD_BIT  7
`define FSV_EVCR_DUAL_BIT  6
`define FSV_EVCR_RSVD_BIT  5
`define FSV_EVCR_HOLD_BIT  4
`define FSV_EVCR_ACC_BIT   3
`define FSV_EVCR_DRV_LSB   0
`define FSV_EVCR_DRV_MSB   2
`define FSV_EVCR_RESET     8'hDF
`define FSV_DRV_RSVD_A     3'h0
`define FSV_DRV_RSVD_B     3'h4

// ----------------------------------------
// address map
// ----------------------------------------
`define FSV_DIE_BIT        25
`define FSV_SEG_ADDR_LSB   24

// ----------------------------------------
// timing counts, 50 ns clock
// ----------------------------------------
`define FSV_STRAP_WAIT     2'h3

`endif

/* File: hw/fsv_regs.v */
// Overview of operation
// - in 3-byte mode the top address byte comes from the segment register
// - segment register bits 1:0 pick one of four 128Mb segments
// - select 11 upper, 10 third, 01 second, 00 lower; default 00
// - program and erase with 3-byte addresses stay in the selected segment
// - 3-byte reads start in the selected segment and stay in its 256Mb die
// - after the last byte of the die a 3-byte read wraps to its first byte
// - segment register is untouched when a read crosses a segment boundary
// - segment select power-up value follows nonvolatile configuration bit 1
// - write-segment command updates the segment select field
// - in 4-byte mode the segment register is ignored, full address used
// - config bit 7 low enables quad protocol; default high, extended SPI
// - config bit 6 low enables dual protocol; default high
// - both bits 6 and 7 low gives quad, quad beats dual
// - protocol change applies right after the configuration write command
// - config bit 4 high enables hold/reset function; default enabled
// - config bit 3 low enables program acceleration; default disabled
// - both registers readable and writable in extended, dual and quad
// - new configuration governs behaviour as soon as the write completes
`include "fsv_map.vh"
`default_nettype none

module fsv_regs (
  input  wire        clk,            // system clock, 20 MHz
  input  wire        rst_b,          // async reset, active low
  input  wire        sclk,           // serial clock from host
  input  wire        cs_b,           // chip select from host, active low
  input  wire [3:0]  dq_in,          // data pins, input side
  output reg  [3:0]  dq_out,         // data pins, output side
  output reg  [3:0]  dq_oe_b,        // data pin drive enable, active low
  input  wire        nvcr_bit1,      // nonvolatile config bit 1 strap
  input  wire        addr4_mode,     // 4-byte address mode active
  input  wire        op_start,       // array operation begins, one cycle
  input  wire        op_is_read,     // operation kind, 1 read, 0 program/erase
  input  wire [31:0] op_addr,        // address as given with the command
  input  wire        op_advance,     // step to next byte, one cycle
  output reg  [31:0] mem_addr_reg,   // physical array address
  output reg  [7:0]  seg_ext_reg,    // segment-extension register
  output reg  [7:0]  evcr_reg        // enhanced volatile configuration
);

  // ----------------------------------------
  // link states and register targets
  // ----------------------------------------
  localparam ST_IDLE  = 3'h0;
  localparam ST_CMD   = 3'h1;
  localparam ST_WDATA = 3'h2;
  localparam ST_RDATA = 3'h3;
  localparam ST_DONE  = 3'h4;

  localparam TGT_SEG  = 1'b0;
  localparam TGT_EVCR = 1'b1;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  wire [5:0] pins_s;
  fsv_sync #(
    .WIDTH (6)
  ) u_sync (
    .clk   (clk),
    .rst_b (rst_b),
    .d     ({nvcr_bit1, sclk, dq_in}),
    .q     (pins_s)
  );

  wire [3:0] dq_s    = pins_s[3:0];
  wire       sclk_s  = pins_s[4];
  wire       strap_s = pins_s[5];

  // chip select gets its own pair so it idles high under reset
  reg cs_meta_reg;
  reg cs_sync_reg;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cs_meta_reg <= 1'b1;
      cs_sync_reg <= 1'b1;
    end else begin
      cs_meta_reg <= cs_b;
      cs_sync_reg <= cs_meta_reg;
    end
  end

  reg sclk_d_reg;
  reg cs_d_reg;
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sclk_d_reg <= 1'b0;
      cs_d_reg   <= 1'b1;
    end else begin
      sclk_d_reg <= sclk_s;
      cs_d_reg   <= cs_sync_reg;
    end
  end

  wire sclk_rise = sclk_s & ~sclk_d_reg & ~cs_sync_reg;
  wire sclk_fall = ~sclk_s & sclk_d_reg & ~cs_sync_reg;
  wire cs_rise   = cs_sync_reg & ~cs_d_reg;

  // ----------------------------------------
  // protocol selection
  // ----------------------------------------
  // quad enable
  wire quad_on = ~evcr_reg[`FSV_EVCR_QUAD_BIT];
  wire dual_on = ~evcr_reg[`FSV_EVCR_DUAL_BIT] & ~quad_on;
  wire [3:0] lanes = quad_on ? 4'h4 : (dual_on ? 4'h2 : 4'h1);

  // ----------------------------------------
  // serial engine
  // ----------------------------------------
  reg [2:0] state_reg;
  reg [7:0] rx_reg;
  reg [3:0] rx_cnt_reg;
  reg [7:0] tx_reg;
  reg [3:0] tx_cnt_reg;
  reg       tgt_reg;
  reg       rd_tgt_reg;
  reg       pend_reg;
  reg [7:0] wr_byte_reg;

  reg [7:0] rx_next;
  reg [3:0] rx_cnt_next;
  always @* begin
    case (lanes)
      4'h4:    rx_next = {rx_reg[3:0], dq_s};
      4'h2:    rx_next = {rx_reg[5:0], dq_s[1], dq_s[0]};
      default: rx_next = {rx_reg[6:0], dq_s[0]};
    endcase
    rx_cnt_next = rx_cnt_reg + lanes;
  end
  wire byte_in = sclk_rise & (rx_cnt_next == 4'h8);

  // value streamed back; reserved bits already held at zero
  wire [7:0] rd_value = rd_tgt_reg ? evcr_reg : seg_ext_reg;

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_reg   <= ST_IDLE;
      rx_reg      <= 8'h00;
      rx_cnt_reg  <= 4'h0;
      tx_reg      <= 8'h00;
      tx_cnt_reg  <= 4'h0;
      tgt_reg     <= TGT_SEG;
      rd_tgt_reg  <= TGT_SEG;
      pend_reg    <= 1'b0;
      wr_byte_reg <= 8'h00;
      dq_out      <= 4'h0;
      dq_oe_b     <= 4'hF;
    end else if (cs_sync_reg) begin
      state_reg  <= ST_IDLE;
      rx_cnt_reg <= 4'h0;
      tx_cnt_reg <= 4'h0;
      pend_reg   <= 1'b0;
      dq_oe_b    <= 4'hF;
    end else begin
      if (state_reg == ST_IDLE) begin
        state_reg <= ST_CMD;
      end
      if (sclk_rise) begin
        rx_reg     <= rx_next;
        rx_cnt_reg <= byte_in ? 4'h0 : rx_cnt_next;
      end
      if (byte_in) begin
        case (state_reg)
          ST_CMD, ST_IDLE: begin
            case (rx_next)
              `FSV_CMD_RD_SEG: begin
                state_reg  <= ST_RDATA;
                rd_tgt_reg <= TGT_SEG;
              end
              `FSV_CMD_RD_EVCR: begin
                state_reg  <= ST_RDATA;
                rd_tgt_reg <= TGT_EVCR;
              end
              `FSV_CMD_WR_SEG: begin
                state_reg <= ST_WDATA;
                tgt_reg   <= TGT_SEG;
              end
              `FSV_CMD_WR_EVCR: begin
                state_reg <= ST_WDATA;
                tgt_reg   <= TGT_EVCR;
              end
              default: begin
                state_reg <= ST_DONE;
              end
            endcase
          end
          ST_WDATA: begin
            // later bytes in the frame are ignored
            wr_byte_reg <= rx_next;
            pend_reg    <= 1'b1;
            state_reg   <= ST_DONE;
          end
          default: begin
            state_reg <= state_reg;
          end
        endcase
      end
      // data leaves on the falling edge so the host samples it stable
      if (sclk_fall && state_reg == ST_RDATA) begin
        case (lanes)
          4'h4: begin
            dq_out  <= (tx_cnt_reg == 4'h0) ? rd_value[7:4] : tx_reg[7:4];
            dq_oe_b <= 4'h0;
          end
          4'h2: begin
            dq_out  <= (tx_cnt_reg == 4'h0) ? {2'h0, rd_value[7:6]}
                                            : {2'h0, tx_reg[7:6]};
            dq_oe_b <= 4'hC;
          end
          default: begin
            dq_out  <= (tx_cnt_reg == 4'h0) ? {2'h0, rd_value[7], 1'b0}
                                            : {2'h0, tx_reg[7], 1'b0};
            dq_oe_b <= 4'hD;
          end
        endcase
        if (tx_cnt_reg == 4'h0) begin
          tx_reg <= (lanes == 4'h4) ? {rd_value[3:0], 4'h0} :
                    (lanes == 4'h2) ? {rd_value[5:0], 2'h0} :
                                      {rd_value[6:0], 1'b0};
        end else begin
          tx_reg <= (lanes == 4'h4) ? {tx_reg[3:0], 4'h0} :
                    (lanes == 4'h2) ? {tx_reg[5:0], 2'h0} :
                                      {tx_reg[6:0], 1'b0};
        end
        // register value repeats while the host keeps clocking
        tx_cnt_reg <= ((tx_cnt_reg + lanes) == 4'h8) ? 4'h0
                                                     : tx_cnt_reg + lanes;
      end
    end
  end

  // ----------------------------------------
  // register bank
  // ----------------------------------------
  reg [1:0] strap_cnt_reg;
  wire      strap_take = (strap_cnt_reg == `FSV_STRAP_WAIT - 2'h1);
  wire      commit     = cs_rise & pend_reg;
  wire [2:0] drv_wr    = wr_byte_reg[`FSV_EVCR_DRV_MSB:`FSV_EVCR_DRV_LSB];
  wire      drv_rsvd   = (drv_wr == `FSV_DRV_RSVD_A) | (drv_wr == `FSV_DRV_RSVD_B);

  // strap waits for the synchroniser to fill before it is caught
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      strap_cnt_reg <= 2'h0;
    end else if (strap_cnt_reg != `FSV_STRAP_WAIT) begin
      strap_cnt_reg <= strap_cnt_reg + 2'h1;
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      seg_ext_reg <= {6'h00, `FSV_SEG_LOWER};
      evcr_reg    <= `FSV_EVCR_RESET;
    end else begin
      if (strap_take) begin
        seg_ext_reg <= {6'h00, (strap_s ? `FSV_SEG_LOWER : `FSV_SEG_UPPER)};
      end else if (commit && tgt_reg == TGT_SEG) begin
        seg_ext_reg <= {6'h00, wr_byte_reg[`FSV_SEG_MSB:`FSV_SEG_LSB]};
      end
      if (commit && tgt_reg == TGT_EVCR) begin
        evcr_reg[`FSV_EVCR_QUAD_BIT] <= wr_byte_reg[`FSV_EVCR_QUAD_BIT];
        evcr_reg[`FSV_EVCR_DUAL_BIT] <= wr_byte_reg[`FSV_EVCR_DUAL_BIT];
        evcr_reg[`FSV_EVCR_RSVD_BIT] <= 1'b0;
        evcr_reg[`FSV_EVCR_HOLD_BIT] <= wr_byte_reg[`FSV_EVCR_HOLD_BIT];
        evcr_reg[`FSV_EVCR_ACC_BIT]  <= wr_byte_reg[`FSV_EVCR_ACC_BIT];
        if (!drv_rsvd) begin
          evcr_reg[`FSV_EVCR_DRV_MSB:`FSV_EVCR_DRV_LSB] <= drv_wr;
        end
      end
    end
  end

  // ----------------------------------------
  // address path
  // ----------------------------------------
  reg        op4_reg;
  reg        op_rd_reg;
  reg [31:0] mem_addr_next;

  always @* begin
    mem_addr_next = mem_addr_reg;
    if (op_start) begin
      if (addr4_mode) begin
        mem_addr_next = op_addr;
      end else begin
        mem_addr_next = {6'h00, seg_ext_reg[`FSV_SEG_MSB:`FSV_SEG_LSB], op_addr[23:0]};
      end
    end else if (op_advance) begin
      if (op4_reg) begin
        mem_addr_next = mem_addr_reg + 32'h0000_0001;
      end else if (op_rd_reg) begin
        mem_addr_next = {mem_addr_reg[31:`FSV_DIE_BIT],
                         mem_addr_reg[`FSV_DIE_BIT-1:0] + 25'h000_0001};
      end else begin
        mem_addr_next = {mem_addr_reg[31:`FSV_SEG_ADDR_LSB],
                         mem_addr_reg[`FSV_SEG_ADDR_LSB-1:0] + 24'h00_0001};
      end
    end
  end

  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mem_addr_reg <= 32'h0000_0000;
      op4_reg      <= 1'b0;
      op_rd_reg    <= 1'b0;
    end else begin
      mem_addr_reg <= mem_addr_next;
      if (op_start) begin
        op4_reg   <= addr4_mode;
        op_rd_reg <= op_is_read;
      end
    end
  end

endmodule // fsv_regs

`default_nettype wire

/* File: hw/fsv_sync.v */
`default_nettype none

module fsv_sync #(
  parameter WIDTH = 6
) (
  input  wire             clk,    // system clock
  input  wire             rst_b,  // async reset, active low
  input  wire [WIDTH-1:0] d,      // asynchronous inputs
  output wire [WIDTH-1:0] q       // synchronised outputs
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      reg meta_reg;
      reg sync_reg;
      // first stage feeds only the second stage
      always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
          meta_reg <= 1'b0;
          sync_reg <= 1'b0;
        end else begin
          meta_reg <= d[i];
          sync_reg <= meta_reg;
        end
      end
      assign q[i] = sync_reg;
    end
  endgenerate

endmodule // fsv_sync

`default_nettype wire

/* File: tb/fsv_host.sv */
`default_nettype none
module fsv_host (
  input  wire logic       clk,     // system clock
  input  wire logic [3:0] dq_out,  // device pin drive
  input  wire logic [3:0] dq_oe_b, // device enables, active low
  output var  logic       sclk,    // serial clock, idle low
  output var  logic       cs_b,    // chip select, active low
  output var  logic [3:0] dq_in    // resolved pin levels
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] h_val = 4'h0;
  logic       h_en = 1'b0;
  initial begin
    sclk = 1'b0;
    cs_b = 1'b1;
  end
  // released pins show the inverse, so a stale level never passes
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      dq_in[i] = !dq_oe_b[i] ? dq_out[i] : (h_en ? h_val[i] : ~h_val[i]);
    end
  end
  task automatic half();
    repeat (4) @(posedge clk);
  endtask
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] wd, input logic wr,
                      input int w, output logic [7:0] rd);
    logic [15:0] sh;
    sh = {cmd, wd};
    rd = 8'h00;
    @(posedge clk);
    cs_b <= 1'b0;
    h_en <= 1'b1;
    half();
    for (int k = 0; k < 16 / w; k++) begin
      if (k == 8 / w && !wr) h_en <= 1'b0;
      h_val <= (w == 4) ? sh[15:12] : (w == 2) ? {2'b00, sh[15:14]} : {3'b000, sh[15]};
      sh = sh << w;
      half();
      sclk <= 1'b1;
      half();
      if (w == 4) rd = {rd[3:0], dq_in};
      else if (w == 2) rd = {rd[5:0], dq_in[1:0]};
      else rd = {rd[6:0], dq_in[1]};
      sclk <= 1'b0;
    end
    half();
    cs_b <= 1'b1;
    h_en <= 1'b0;
    repeat (12) @(posedge clk);
  endtask
endmodule // fsv_host
`default_nettype wire

/* File: tb/fsv_monitor.sv */
`default_nettype none
module fsv_monitor (
  input wire logic        clk,          // system clock
  input wire logic        rst_b,        // reset, active low
  input wire logic        cs_b,         // chip select, active low
  input wire logic [3:0]  dq_oe_b,      // pin enables, active low
  input wire logic        addr4_mode,   // 4-byte mode
  input wire logic        op_start,     // op begins
  input wire logic        op_is_read,   // op kind
  input wire logic [31:0] op_addr,      // issued address
  input wire logic        op_advance,   // byte step
  input wire logic [31:0] mem_addr_reg, // array address
  input wire logic [7:0]  seg_ext_reg,  // segment register
  input wire logic [7:0]  evcr_reg      // config register
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  logic rd_kind_reg;
  logic a4_kind_reg;
  // op kind held from op_start, as the stepping rule depends on it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_kind_reg <= 1'b0;
      a4_kind_reg <= 1'b0;
    end else if (op_start) begin
      rd_kind_reg <= op_is_read;
      a4_kind_reg <= addr4_mode;
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  sequence s_cs_idle;
    cs_b[*6];
  endsequence
  sequence s_rd_step;
    op_advance && !op_start && rd_kind_reg && !a4_kind_reg;
  endsequence
  sequence s_pe_step;
    op_advance && !op_start && !rd_kind_reg && !a4_kind_reg;
  endsequence
  chk_addr_three: assert property (
    op_start && !addr4_mode |=>
      mem_addr_reg == {6'h00, $past(seg_ext_reg[1:0]), $past(op_addr[23:0])})
    else $error("3-byte address mismatch");
  chk_addr_four: assert property (
    op_start && addr4_mode |=> mem_addr_reg == $past(op_addr))
    else $error("4-byte address mismatch");
  chk_read_wrap: assert property (
    s_rd_step |=> mem_addr_reg == {$past(mem_addr_reg[31:25]), $past(mem_addr_reg[24:0]) + 25'h1})
    else $error("read step left its die");
  chk_pe_wrap: assert property (
    s_pe_step |=> mem_addr_reg == {$past(mem_addr_reg[31:24]), $past(mem_addr_reg[23:0]) + 24'h1})
    else $error("program step left its segment");
  chk_seg_upper: assert property (seg_ext_reg[7:2] == 6'h00)
    else $error("segment upper bits set");
  chk_evcr_rsvd: assert property (evcr_reg[5] == 1'b0)
    else $error("config reserved bit set");
  chk_drv_legal: assert property (
    evcr_reg[2:0] != 3'h0 && evcr_reg[2:0] != 3'h4)
    else $error("reserved drive code held");
  chk_seg_commit: assert property ($changed(seg_ext_reg) |-> $past(cs_b))
    else $error("segment changed inside a frame");
  chk_evcr_commit: assert property ($changed(evcr_reg) |-> $past(cs_b, 2))
    else $error("config changed inside a frame");
  chk_oe_release: assert property (s_cs_idle |-> dq_oe_b == 4'hF)
    else $error("pins driven while deselected");
endmodule // fsv_monitor
`default_nettype wire

/* File: tb/tb_fsv_regs.sv */
`default_nettype none
module tb_fsv_regs;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk;
  logic        rst_b;
  logic        nvcr_bit1;
  logic        addr4_mode;
  logic        op_start;
  logic        op_is_read;
  logic        op_advance;
  logic [31:0] op_addr;
  logic        sclk;
  logic        cs_b;
  logic [3:0]  dq_in;
  logic [3:0]  dq_out;
  logic [3:0]  dq_oe_b;
  logic [31:0] mem_addr_reg;
  logic [7:0]  seg_ext_reg;
  logic [7:0]  evcr_reg;
  logic [7:0]  rd;
  int          n_mismatch = 0;
  int          tests_run = 0;

  fsv_regs u_dut (.clk(clk), .rst_b(rst_b), .sclk(sclk), .cs_b(cs_b), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe_b(dq_oe_b), .nvcr_bit1(nvcr_bit1), .addr4_mode(addr4_mode),
    .op_start(op_start), .op_is_read(op_is_read), .op_addr(op_addr), .op_advance(op_advance),
    .mem_addr_reg(mem_addr_reg), .seg_ext_reg(seg_ext_reg), .evcr_reg(evcr_reg));
  fsv_host u_host (.clk(clk), .dq_out(dq_out), .dq_oe_b(dq_oe_b), .sclk(sclk), .cs_b(cs_b),
    .dq_in(dq_in));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic complete_run();
    if (n_mismatch == 0 && tests_run > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic do_reset(input logic strap);
    nvcr_bit1 <= strap;
    rst_b <= 1'b0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    repeat (6) @(posedge clk);
  endtask

  task automatic pulse(input logic adv, input logic rdo, input logic a4, input logic [31:0] a);
    op_start <= !adv;
    op_advance <= adv;
    op_is_read <= rdo;
    addr4_mode <= a4;
    op_addr <= a;
    @(posedge clk);
    op_start <= 1'b0;
    op_advance <= 1'b0;
    @(posedge clk);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset();
    check("seg reset", seg_ext_reg, 32'h00);
    check("evcr reset", evcr_reg, 32'hDF);
    u_host.xfer(8'h65, 8'h00, 1'b0, 1, rd);
    check("evcr read", rd, 32'hDF);
    do_reset(1'b0);
    check("seg strap", seg_ext_reg, 32'h03);
    do_reset(1'b1);
  endtask

  task automatic t_seg();
    for (int v = 0; v < 4; v++) begin
      u_host.xfer(8'hC5, 8'hFC | v[7:0], 1'b1, 1, rd);
      check("seg write", seg_ext_reg, v);
      u_host.xfer(8'hC8, 8'h00, 1'b0, 1, rd);
      check("seg read", rd, v);
    end
    u_host.xfer(8'h00, 8'h01, 1'b1, 1, rd);
    check("seg unknown cmd", seg_ext_reg, 32'h03);
  endtask

  task automatic t_addr();
    for (int v = 0; v < 4; v++) begin
      u_host.xfer(8'hC5, v[7:0], 1'b1, 1, rd);
      pulse(1'b0, 1'b1, 1'b0, 32'hA5123456);
      check("addr 3-byte", mem_addr_reg, {6'h00, v[1:0], 24'h123456});
      pulse(1'b0, 1'b0, 1'b1, 32'hA5123456);
      check("addr 4-byte", mem_addr_reg, 32'hA5123456);
    end
  endtask

  task automatic wcase(input logic [7:0] sg, input logic rdo, input logic a4,
                       input logic [31:0] a, input logic [31:0] exp);
    u_host.xfer(8'hC5, sg, 1'b1, 1, rd);
    pulse(1'b0, rdo, a4, a);
    pulse(1'b1, rdo, a4, a);
    check("addr step", mem_addr_reg, exp);
    check("seg kept", seg_ext_reg, sg);
  endtask

  task automatic t_wrap();
    wcase(8'h00, 1'b1, 1'b0, 32'h00FFFFFF, 32'h01000000);
    wcase(8'h03, 1'b1, 1'b0, 32'h00FFFFFF, 32'h02000000);
    wcase(8'h01, 1'b1, 1'b0, 32'h00FFFFFF, 32'h00000000);
    wcase(8'h02, 1'b0, 1'b0, 32'h00FFFFFF, 32'h02000000);
    wcase(8'h01, 1'b0, 1'b0, 32'h00FFFFFF, 32'h01000000);
    wcase(8'h00, 1'b1, 1'b1, 32'h01FFFFFF, 32'h02000000);
  endtask

  task automatic t_evcr();
    u_host.xfer(8'h61, 8'h9F, 1'b1, 1, rd);
    check("evcr to dual", evcr_reg, 32'h9F);
    u_host.xfer(8'h65, 8'h00, 1'b0, 2, rd);
    check("evcr read dual", rd, 32'h9F);
    u_host.xfer(8'h61, 8'h1F, 1'b1, 2, rd);
    u_host.xfer(8'hC5, 8'h02, 1'b1, 4, rd);
    u_host.xfer(8'hC8, 8'h00, 1'b0, 4, rd);
    check("seg read quad", rd, 32'h02);
    u_host.xfer(8'h61, 8'h18, 1'b1, 4, rd);
    check("drive code 000", evcr_reg, 32'h1F);
    u_host.xfer(8'h61, 8'h2C, 1'b1, 4, rd);
    check("drive code 100", evcr_reg, 32'h0F);
    u_host.xfer(8'h65, 8'h00, 1'b0, 4, rd);
    check("evcr read quad", rd, 32'h0F);
    u_host.xfer(8'h61, 8'hC5, 1'b1, 4, rd);
    u_host.xfer(8'h65, 8'h00, 1'b0, 1, rd);
    check("evcr read ext", rd, 32'hC5);
  endtask

  initial begin
    rst_b = 1'b0;
    nvcr_bit1 = 1'b1;
    addr4_mode = 1'b0;
    op_start = 1'b0;
    op_is_read = 1'b0;
    op_advance = 1'b0;
    op_addr = 32'h00000000;
    do_reset(1'b1);
    t_reset();
    t_seg();
    t_addr();
    t_wrap();
    t_evcr();
    complete_run();
  end

  initial begin
    repeat (60000) @(posedge clk);
    n_mismatch++;
    complete_run();
  end
endmodule // tb_fsv_regs

bind fsv_regs fsv_monitor u_mon (.clk(clk), .rst_b(rst_b), .cs_b(cs_b), .dq_oe_b(dq_oe_b),
  .addr4_mode(addr4_mode), .op_start(op_start), .op_is_read(op_is_read), .op_addr(op_addr),
  .op_advance(op_advance), .mem_addr_reg(mem_addr_reg), .seg_ext_reg(seg_ext_reg),
  .evcr_reg(evcr_reg));
`default_nettype wire
